/* bct_pkg.sv */
// bct_pkg: constants and carrier types for the bit error rate tester result logic
package bct_pkg;
	// host port geometry
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	// register offsets on the microprocessor port
	localparam logic [12:0] OFS_CONTROL = 13'h1104;
	localparam logic [12:0] OFS_BIT_B0 = 13'h1107;
	localparam logic [12:0] OFS_BIT_B1 = 13'h1108;
	localparam logic [12:0] OFS_BIT_B2 = 13'h1109;
	localparam logic [12:0] OFS_BIT_B3 = 13'h110A;
	localparam logic [12:0] OFS_ERR_B0 = 13'h110B;
	localparam logic [12:0] OFS_ERR_B1 = 13'h110C;
	localparam logic [12:0] OFS_ERR_B2 = 13'h110D;
	localparam logic [12:0] OFS_STATUS = 13'h110E;
	localparam logic [12:0] OFS_MASK = 13'h110F;
	// control register fields
	localparam int CTRL_REACQ_BIT = 0;
	localparam int CTRL_LOAD_BIT = 1;
	localparam int CTRL_W = 2;
	// status and mask field positions
	localparam int ST_SYNC = 0;
	localparam int ST_LOS = 1;
	localparam int ST_ZEROS = 2;
	localparam int ST_ONES = 3;
	localparam int ST_ECO = 4;
	localparam int ST_BCO = 5;
	localparam int ST_ERR = 6;
	localparam int STATUS_W = 7;
	localparam int COND_W = 4;
	// reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [3:0] COND_RESET = 4'h2;
	// counter widths and run lengths
	localparam int BIT_CNT_W = 32;
	localparam int ERR_CNT_W = 24;
	localparam int RUN_LEN = 32;
	localparam int LOCK_RUN_LEN = 32;
	localparam int LOSS_WINDOW = 64;
	localparam int LOSS_ERRORS = 6;
	// host access request
	typedef struct packed
	{
		logic cs;
		logic rd;
		logic wr;
		logic [12:0] addr;
		logic [7:0] wdata;
	} bct_host_t;
	// one received bit with the pattern's expected bit
	typedef struct packed
	{
		logic valid;
		logic data;
		logic expected;
	} bct_rx_t;
endpackage

/* bct_sync_checker.sv */
// bct_sync_checker: pattern lock search and loss detection for the receive checker
module bct_sync_checker
	import bct_pkg::*;
#(
	parameter int LOCK_RUN = LOCK_RUN_LEN,
	parameter int LOSS_WIN = LOSS_WINDOW,
	parameter int LOSS_ERR = LOSS_ERRORS
)
(
	input wire logic clock,
	input wire logic reset,
	input bct_rx_t rx,
	input wire logic reacquire,
	output logic locked,
	output logic search_enter,
	output logic bit_err,
	output logic bit_seen
);
	localparam int MW = $clog2(LOCK_RUN + 1);
	localparam int WW = $clog2(LOSS_WIN + 1);
	typedef enum logic {S_SEARCH, S_LOCK} bct_chk_state_t;
	bct_chk_state_t state_r;
	bct_chk_state_t state_nxt;
	logic [MW-1:0] match_r;
	logic [MW-1:0] match_nxt;
	logic [WW-1:0] win_r;
	logic [WW-1:0] win_nxt;
	logic [WW-1:0] errs_r;
	logic [WW-1:0] errs_nxt;
	logic mismatch;
	logic good_bit;
	logic lock_now;
	logic lose_now;
	logic win_end;

	// bit classification
	assign mismatch = rx.valid & (rx.data ^ rx.expected);
	assign good_bit = rx.valid & ~mismatch;
	assign locked = (state_r == S_LOCK);
	assign lock_now = ~locked & good_bit & (match_r == MW'(LOCK_RUN - 1));
	assign lose_now = locked & mismatch & (errs_r >= WW'(LOSS_ERR - 1));
	assign win_end = rx.valid & (win_r == WW'(LOSS_WIN - 1));
	assign search_enter = reacquire | lose_now;
	assign bit_err = locked & mismatch;
	assign bit_seen = locked & rx.valid;

	// next state and counters
	always_comb
	begin
		state_nxt = state_r;
		match_nxt = match_r;
		win_nxt = win_r;
		errs_nxt = errs_r;
		case (state_r)
			S_SEARCH:
			begin
				if (mismatch)
					match_nxt = '0;
				else if (good_bit)
					match_nxt = match_r + MW'(1);
				if (lock_now)
				begin
					state_nxt = S_LOCK;
					win_nxt = '0;
					errs_nxt = '0;
				end
			end
			S_LOCK:
			begin
				win_nxt = win_end ? '0 : (rx.valid ? win_r + WW'(1) : win_r);
				errs_nxt = win_end ? '0 : (mismatch ? errs_r + WW'(1) : errs_r);
				if (lose_now)
					state_nxt = S_SEARCH;
			end
			default:
				state_nxt = S_SEARCH;
		endcase
		if (reacquire)
			state_nxt = S_SEARCH;
		if (search_enter)
			match_nxt = '0;
	end

	// state registers
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			state_r <= S_SEARCH;
			match_r <= '0;
			win_r <= '0;
			errs_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			match_r <= match_nxt;
			win_r <= win_nxt;
			errs_r <= errs_nxt;
		end
	end

	property p_lock_after_run;
		@(posedge clock) disable iff (reset)
		$rose(locked) |-> ($past(match_r) == MW'(LOCK_RUN - 1));
	endproperty
	a_lock_after_run: assert property (p_lock_after_run) else $error("lock without full matching run");

	property p_reacquire_drops;
		@(posedge clock) disable iff (reset)
		reacquire |=> !locked ##1 (!locked || $past(lock_now));
	endproperty
	a_reacquire_drops: assert property (p_reacquire_drops) else $error("lock kept after reacquire");
endmodule

/* bct_top.sv */
// bct_top: bit error rate tester counters, latched status, mask and host registers
module bct_top
	import bct_pkg::*;
#(
	parameter int BIT_W = BIT_CNT_W,
	parameter int ERR_W = ERR_CNT_W,
	parameter int RUN = RUN_LEN
)
(
	input wire logic clock,
	input wire logic reset,
	input bct_host_t host,
	output logic [7:0] rd_data_r,
	input bct_rx_t rx,
	output logic irq
);
	localparam int RW = $clog2(RUN + 1);
	logic [CTRL_W-1:0] ctrl_r;
	logic [CTRL_W-1:0] ctrl_prev_r;
	logic [BIT_W-1:0] bit_cnt_r;
	logic [BIT_W-1:0] bit_snap_r;
	logic [ERR_W-1:0] err_cnt_r;
	logic [ERR_W-1:0] err_snap_r;
	logic [RW-1:0] ones_run_r;
	logic [RW-1:0] zeros_run_r;
	logic [COND_W-1:0] cond_prev_r;
	logic [STATUS_W-1:0] status_r;
	logic [STATUS_W-1:0] status_nxt;
	logic [STATUS_W-1:0] mask_r;
	logic [COND_W-1:0] cond_now;
	logic [COND_W-1:0] cond_edge;
	logic [STATUS_W-1:0] set_vec;
	logic [STATUS_W-1:0] level_vec;
	logic rd_strobe;
	logic wr_strobe;
	logic status_clr;
	logic load_pulse;
	logic reacq_pulse;
	logic locked;
	logic search_enter;
	logic bit_err;
	logic bit_seen;
	logic bit_wrap;
	logic err_wrap;
	logic all_ones;
	logic all_zeros;
	logic [7:0] rd_mux;

	// run length step, saturating at the run length
	function automatic logic [RW-1:0] bct_run_step(input logic [RW-1:0] run, input logic hit);
		bct_run_step = !hit ? '0 : ((run == RW'(RUN)) ? run : run + RW'(1));
	endfunction

	bct_sync_checker u_checker
	(
		.clock(clock),
		.reset(reset),
		.rx(rx),
		.reacquire(reacq_pulse),
		.locked(locked),
		.search_enter(search_enter),
		.bit_err(bit_err),
		.bit_seen(bit_seen)
	);

	// host strobes and control edges
	assign rd_strobe = host.cs & host.rd;
	assign wr_strobe = host.cs & host.wr;
	assign status_clr = rd_strobe & (host.addr == OFS_STATUS);
	assign load_pulse = ctrl_r[CTRL_LOAD_BIT] & ~ctrl_prev_r[CTRL_LOAD_BIT];
	assign reacq_pulse = ctrl_r[CTRL_REACQ_BIT] & ~ctrl_prev_r[CTRL_REACQ_BIT];

	// counter wrap and run conditions
	assign bit_wrap = bit_seen & (&bit_cnt_r);
	assign err_wrap = bit_err & (&err_cnt_r);
	assign all_ones = (ones_run_r == RW'(RUN));
	assign all_zeros = (zeros_run_r == RW'(RUN));

	// status sources: edges of conditions and one-shot events
	assign cond_now = {all_ones, all_zeros, ~locked, locked};
	assign cond_edge = cond_now ^ cond_prev_r;
	assign set_vec = {bit_err, bit_wrap, err_wrap, cond_edge[3], cond_edge[2],
		cond_edge[1] | search_enter, cond_edge[0]};
	assign level_vec = {3'h0, cond_now};
	// set wins over the read clear, a live condition stays latched
	assign status_nxt = (status_r & ~{STATUS_W{status_clr}}) | set_vec
		| ({STATUS_W{status_clr}} & level_vec);
	assign irq = |(status_r & mask_r);

	// read data selection, unmapped reads as zero
	assign rd_mux = (host.addr == OFS_CONTROL) ? {6'h00, ctrl_r} :
		(host.addr == OFS_BIT_B0) ? bit_snap_r[7:0] :
		(host.addr == OFS_BIT_B1) ? bit_snap_r[15:8] :
		(host.addr == OFS_BIT_B2) ? bit_snap_r[23:16] :
		(host.addr == OFS_BIT_B3) ? bit_snap_r[31:24] :
		(host.addr == OFS_ERR_B0) ? err_snap_r[7:0] :
		(host.addr == OFS_ERR_B1) ? err_snap_r[15:8] :
		(host.addr == OFS_ERR_B2) ? err_snap_r[23:16] :
		(host.addr == OFS_STATUS) ? {1'b0, status_r} :
		(host.addr == OFS_MASK) ? {1'b0, mask_r} : RESET_BYTE;

	// host registers
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			ctrl_r <= '0;
			ctrl_prev_r <= '0;
			mask_r <= '0;
			rd_data_r <= RESET_BYTE;
		end
		else
		begin
			ctrl_prev_r <= ctrl_r;
			if (wr_strobe && host.addr == OFS_CONTROL)
				ctrl_r <= host.wdata[CTRL_W-1:0];
			if (wr_strobe && host.addr == OFS_MASK)
				mask_r <= host.wdata[STATUS_W-1:0];
			if (rd_strobe)
				rd_data_r <= rd_mux;
		end
	end

	// running counts and load snapshots
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			bit_cnt_r <= '0;
			err_cnt_r <= '0;
			bit_snap_r <= '0;
			err_snap_r <= '0;
		end
		else if (load_pulse)
		begin
			bit_snap_r <= bit_cnt_r;
			err_snap_r <= err_cnt_r;
			bit_cnt_r <= BIT_W'(bit_seen);
			err_cnt_r <= ERR_W'(bit_err);
		end
		else
		begin
			bit_cnt_r <= bit_cnt_r + BIT_W'(bit_seen);
			err_cnt_r <= err_cnt_r + ERR_W'(bit_err);
		end
	end

	// run detectors and latched status
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			ones_run_r <= '0;
			zeros_run_r <= '0;
			cond_prev_r <= COND_RESET;
			status_r <= '0;
		end
		else
		begin
			if (rx.valid)
			begin
				ones_run_r <= bct_run_step(ones_run_r, rx.data);
				zeros_run_r <= bct_run_step(zeros_run_r, ~rx.data);
			end
			cond_prev_r <= cond_now;
			status_r <= status_nxt;
		end
	end

	property p_bit_wrap;
		@(posedge clock) disable iff (reset)
		bit_wrap |=> status_r[ST_BCO];
	endproperty
	a_bit_wrap: assert property (p_bit_wrap) else $error("bit overflow not flagged");

	property p_err_wrap;
		@(posedge clock) disable iff (reset)
		err_wrap |=> status_r[ST_ECO] && err_cnt_r == ERR_W'($past(load_pulse));
	endproperty
	a_err_wrap: assert property (p_err_wrap) else $error("error overflow not flagged");

	property p_err_only_locked;
		@(posedge clock) disable iff (reset)
		(!locked && !load_pulse) |=> $stable(err_cnt_r) && !(status_r[ST_ERR] && !$past(status_r[ST_ERR]));
	endproperty
	a_err_only_locked: assert property (p_err_only_locked) else $error("error counted out of lock");

	property p_ones_run;
		@(posedge clock) disable iff (reset)
		(rx.valid && rx.data && ones_run_r == RW'(RUN - 1)) |=> ##1 status_r[ST_ONES];
	endproperty
	a_ones_run: assert property (p_ones_run) else $error("all-ones run not flagged");

	property p_zeros_run;
		@(posedge clock) disable iff (reset)
		(rx.valid && !rx.data && zeros_run_r == RW'(RUN - 1)) |=> ##1 status_r[ST_ZEROS];
	endproperty
	a_zeros_run: assert property (p_zeros_run) else $error("all-zeros run not flagged");

	property p_search_flag;
		@(posedge clock) disable iff (reset)
		search_enter |=> status_r[ST_LOS];
	endproperty
	a_search_flag: assert property (p_search_flag) else $error("search entry not flagged");

	property p_cond_edge;
		@(posedge clock) disable iff (reset)
		(cond_edge != '0) |=> ((status_r[3:0] & $past(cond_edge)) == $past(cond_edge));
	endproperty
	a_cond_edge: assert property (p_cond_edge) else $error("condition edge not latched");

	property p_load;
		@(posedge clock) disable iff (reset)
		load_pulse |=> bit_snap_r == $past(bit_cnt_r) && err_snap_r == $past(err_cnt_r) && bit_cnt_r <= BIT_W'(1);
	endproperty
	a_load: assert property (p_load) else $error("load did not snapshot and clear");

	property p_hold;
		@(posedge clock) disable iff (reset)
		!status_clr |=> ((status_r & $past(status_r)) == $past(status_r));
	endproperty
	a_hold: assert property (p_hold) else $error("latched flag dropped without read");

	property p_mask_gate;
		@(posedge clock) disable iff (reset)
		(mask_r == '0) |-> !irq;
	endproperty
	a_mask_gate: assert property (p_mask_gate) else $error("masked flag raised interrupt");

	property p_top_bit;
		@(posedge clock) disable iff (reset)
		(rd_strobe && (host.addr == OFS_STATUS || host.addr == OFS_MASK)) |=> !rd_data_r[7];
	endproperty
	a_top_bit: assert property (p_top_bit) else $error("reserved top bit read nonzero");

	property p_byte_order;
		@(posedge clock) disable iff (reset)
		(rd_strobe && host.addr == OFS_BIT_B3 && !load_pulse) |=> rd_data_r == bit_snap_r[31:24];
	endproperty
	a_byte_order: assert property (p_byte_order) else $error("bit count top byte misplaced");
endmodule

/* bct_host_model.sv */
// bct_host_model: host processor model driving the register port
module bct_host_model
	import bct_pkg::*;
(
	input wire logic clock,
	input wire logic [7:0] rd_data,
	output bct_host_t host
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle bus at time zero
	initial host = '0;

	// one access held over exactly one sampling edge, then released
	task automatic access(input logic wr, input logic [12:0] addr, input logic [7:0] wdata);
		@(posedge clock);
		host <= '{cs: 1'b1, rd: ~wr, wr: wr, addr: addr, wdata: wdata};
		@(posedge clock);
		// released address and data lines show no stale value
		host <= '{cs: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
	endtask

	// read data is taken once the registered answer has landed
	task automatic read_reg(input logic [12:0] addr, output logic [7:0] data);
		access(1'b0, addr, 8'h00);
		@(posedge clock);
		#1 data = rd_data;
	endtask

	task automatic write_reg(input logic [12:0] addr, input logic [7:0] wdata);
		access(1'b1, addr, wdata);
	endtask

	// low then high on one control bit, then wait until the effect is readable
	task automatic pulse_control(input int idx);
		write_reg(OFS_CONTROL, 8'h00);
		write_reg(OFS_CONTROL, 8'h01 << idx);
		repeat (2) @(posedge clock);
	endtask
endmodule

/* tb_bert_counters_status.sv */
// tb_bert_counters_status: self-checking bench for the tester result logic
module tb_bert_counters_status
	import bct_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [63:0] ALT = 64'h5555_5555_5555_5555;
	logic clock = 1'b0;
	logic reset = 1'b1;
	bct_host_t host;
	bct_rx_t rx = '0;
	logic [7:0] rd_data_r;
	logic irq;
	logic [7:0] rv;
	int failures = 0;
	int comparisons = 0;

	// 250 MHz clock
	always #2 clock = ~clock;

	bct_top DUT (.clock(clock), .reset(reset), .host(host), .rd_data_r(rd_data_r), .rx(rx), .irq(irq));
	bct_host_model u_host (.clock(clock), .rd_data(rd_data_r), .host(host));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		if (failures == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// n received bits, low end first; idle lines then show the inverse
	task automatic send(input logic [63:0] d, input logic [63:0] e, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clock);
			rx <= '{valid: 1'b1, data: d[i], expected: e[i]};
		end
		@(posedge clock);
		rx <= '{valid: 1'b0, data: ~d[n-1], expected: ~e[n-1]};
	endtask

	// all count bytes, least significant first
	task automatic check_counts(input logic [31:0] bits, input logic [23:0] errs);
		for (int i = 0; i < 4; i++)
		begin
			u_host.read_reg(OFS_BIT_B0 + 13'(i), rv);
			check(rv, bits[8*i +: 8]);
		end
		for (int i = 0; i < 3; i++)
		begin
			u_host.read_reg(OFS_ERR_B0 + 13'(i), rv);
			check(rv, errs[8*i +: 8]);
		end
	endtask

	task automatic check_irq(input logic exp);
		@(posedge clock);
		#1 check({7'h00, irq}, {7'h00, exp});
	endtask

	// reset values, read-only byte, unused mask bit, unmapped address
	task automatic s_reset();
		check_counts(32'h0000_0000, 24'h00_0000);
		u_host.read_reg(OFS_STATUS, rv);
		check(rv, 8'h00);
		u_host.read_reg(OFS_MASK, rv);
		check(rv, 8'h00);
		u_host.write_reg(OFS_BIT_B0, 8'hAA);
		u_host.write_reg(OFS_MASK, 8'hFF);
		u_host.read_reg(OFS_MASK, rv);
		check(rv, 8'h7F);
		u_host.read_reg(OFS_BIT_B0, rv);
		check(rv, 8'h00);
		u_host.read_reg(13'h1000, rv);
		check(rv, 8'h00);
		u_host.write_reg(OFS_MASK, 8'h00);
	endtask

	// lock after 32 matching bits, mask gating, read clearing
	task automatic s_lock();
		send(ALT, ALT, 32);
		check_irq(1'b0);
		u_host.write_reg(OFS_MASK, 8'h01);
		check_irq(1'b1);
		u_host.read_reg(OFS_STATUS, rv);
		check(rv & 8'h03, 8'h03);
		u_host.read_reg(OFS_STATUS, rv);
		check(rv & 8'h02, 8'h00);
		u_host.write_reg(OFS_MASK, 8'h00);
	endtask

	// 40 bits in lock with 3 mismatches between two loads
	task automatic s_counts();
		u_host.pulse_control(CTRL_LOAD_BIT);
		send(ALT, ALT ^ 64'h0000_0000_4002_0020, 40);
		u_host.pulse_control(CTRL_LOAD_BIT);
		check_counts(32'h0000_0028, 24'h00_0003);
		u_host.read_reg(OFS_STATUS, rv);
		check(rv & 8'h41, 8'h41);
	endtask

	// forced search, then mismatches out of lock count nothing
	task automatic s_reacquire();
		u_host.read_reg(OFS_STATUS, rv);
		u_host.pulse_control(CTRL_REACQ_BIT);
		u_host.read_reg(OFS_STATUS, rv);
		check(rv & 8'h02, 8'h02);
		send(ALT, ~ALT, 20);
		u_host.pulse_control(CTRL_LOAD_BIT);
		check_counts(32'h0000_0000, 24'h00_0000);
	endtask

	// runs of ones and zeros, start and end events
	task automatic s_runs();
		u_host.write_reg(OFS_MASK, 8'h08);
		check_irq(1'b0);
		send('1, '1, 40);
		repeat (2) @(posedge clock);
		check_irq(1'b1);
		u_host.read_reg(OFS_STATUS, rv);
		check(rv & 8'h08, 8'h08);
		send('0, '0, 40);
		repeat (3) @(posedge clock);
		u_host.read_reg(OFS_STATUS, rv);
		check(rv & 8'h0C, 8'h0C);
		send(ALT, ALT, 8);
		repeat (3) @(posedge clock);
		u_host.read_reg(OFS_STATUS, rv);
		u_host.read_reg(OFS_STATUS, rv);
		check(rv & 8'h0C, 8'h00);
	endtask

	// reset in mid-run clears snapshots, status and mask
	task automatic s_reset_again();
		u_host.pulse_control(CTRL_LOAD_BIT);
		u_host.read_reg(OFS_BIT_B0, rv);
		check(rv, 8'h38);
		@(posedge clock);
		reset <= 1'b1;
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		check_irq(1'b0);
		check_counts(32'h0000_0000, 24'h00_0000);
		u_host.read_reg(OFS_STATUS, rv);
		check(rv, 8'h00);
		u_host.read_reg(OFS_MASK, rv);
		check(rv, 8'h00);
	endtask

	// main sequence
	initial
	begin
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		s_reset();
		s_lock();
		s_counts();
		s_reacquire();
		s_runs();
		s_reset_again();
		give_verdict();
	end

	// watchdog cutting a hung run short
	initial
	begin
		for (int i = 0; i < 20000; i++)
			@(posedge clock);
		failures++;
		give_verdict();
	end
endmodule
